// file: include/aiss_pkg.sv
package aiss_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CH0_SEL = 4'h0;
    localparam logic [3:0] REG_SCAN_HI = 4'h1;
    localparam logic [3:0] REG_CFG = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;

    localparam logic [15:0] CH0_SEL_RESET = 16'h0000;
    localparam logic [15:0] SCAN_HI_RESET = 16'h0000;
    localparam logic [15:0] CH0_SEL_MASK = 16'h9F9F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_A_LSB = 0;
    localparam int NEG_A_BIT = 7;
    localparam int POS_B_LSB = 8;
    localparam int NEG_B_BIT = 15;
    localparam int SEL_W = 5;
    localparam int SCAN_W = 16;
    localparam int SCAN_BASE = 16;
    localparam logic [4:0] SECOND_MAX_INPUT = 5'h0F;
    localparam logic [4:0] NEG_PIN_INPUT = 5'h01;
    localparam logic [5:0] PRESENT_RESET = 6'h20;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } aiss_bus_s;

    typedef struct packed {
        logic neg_pin_b;
        logic [4:0] pos_b;
        logic neg_pin_a;
        logic [4:0] pos_a;
    } aiss_sel_s;

    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_SEEK = 3'b010,
        SCAN_EMIT = 3'b100
    } aiss_scan_e;

endpackage

// file: core/aiss_regs.sv
module aiss_regs
    import aiss_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_second,
    input aiss_bus_s i_bus,
    output logic [15:0] o_ch0_sel,
    output logic [15:0] o_scan_hi,
    output logic [5:0] o_present
);
    logic [15:0] ch0_q, ch0_d, scan_q, scan_d;
    logic [5:0] pres_q, pres_d;

    // Positive selects wider than the second converter allows are clipped.
    function automatic logic [4:0] clip_sel(input logic [4:0] s, input logic sec);
        clip_sel = (sec && s > SECOND_MAX_INPUT) ? SECOND_MAX_INPUT : s;
    endfunction

    always_comb begin
        ch0_d = ch0_q;
        scan_d = scan_q;
        pres_d = pres_q;
        if (i_bus.wr) begin
            case (i_bus.addr)
                REG_CH0_SEL: begin
                    ch0_d = i_bus.wdata & CH0_SEL_MASK;
                    ch0_d[POS_A_LSB +: SEL_W] = clip_sel(i_bus.wdata[POS_A_LSB +: SEL_W], i_second);
                    ch0_d[POS_B_LSB +: SEL_W] = clip_sel(i_bus.wdata[POS_B_LSB +: SEL_W], i_second);
                end
                REG_SCAN_HI: scan_d = i_bus.wdata;
                REG_CFG: pres_d = i_bus.wdata[5:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ch0_q <= CH0_SEL_RESET;
            scan_q <= SCAN_HI_RESET;
            pres_q <= PRESENT_RESET;
        end else begin
            ch0_q <= ch0_d;
            scan_q <= scan_d;
            pres_q <= pres_d;
        end
    end

    assign o_ch0_sel = ch0_q;
    assign o_scan_hi = scan_q;
    assign o_present = pres_q;
endmodule

// file: core/aiss_scan.sv
module aiss_scan
    import aiss_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic i_step,
    input wire logic [15:0] i_mask,
    output logic [4:0] o_input,
    output logic o_valid,
    output logic o_last,
    output logic o_busy
);
    aiss_scan_e st_q, st_d;
    logic [3:0] idx_q, idx_d;
    logic [15:0] mask_q, mask_d;

    // The mask is captured at start so a write mid-scan cannot tear the sequence.
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        mask_d = mask_q;
        case (st_q)
            SCAN_IDLE: begin
                if (i_start && i_mask != 16'h0000) begin
                    mask_d = i_mask;
                    idx_d = 4'h0;
                    st_d = SCAN_SEEK;
                end
            end
            SCAN_SEEK: begin
                if (mask_q[idx_q]) begin
                    st_d = SCAN_EMIT;
                end else if (idx_q == 4'hF) begin
                    st_d = SCAN_IDLE;
                end else begin
                    idx_d = idx_q + 4'h1;
                end
            end
            SCAN_EMIT: begin
                if (i_step) begin
                    if (idx_q == 4'hF || (mask_q >> idx_q) == 16'h0001) begin
                        st_d = SCAN_IDLE;
                    end else begin
                        idx_d = idx_q + 4'h1;
                        st_d = SCAN_SEEK;
                    end
                end
            end
            default: st_d = SCAN_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st_q <= SCAN_IDLE;
            idx_q <= 4'h0;
            mask_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            mask_q <= mask_d;
        end
    end

    assign o_input = {1'b1, idx_q};
    assign o_valid = (st_q == SCAN_EMIT);
    assign o_last = (st_q == SCAN_EMIT) && (idx_q == 4'hF || (mask_q >> idx_q) == 16'h0001);
    assign o_busy = (st_q != SCAN_IDLE);
endmodule

// file: core/aiss_top.sv
// Behaviour
// - Sample A channel 0 negative input is analog input 1 when bit 7 set, else low reference.
// - Sample A negative select resets to the low reference.
// - Second converter clips channel 0 positive selects to inputs 0 through 15.
// - Mask bit one includes that input in the scan; zero skips it.
// - Upper mask bits 15..0 map onto analog inputs 31..16.
// - All sixteen upper mask bits are writable and readable on every variant.
module aiss_top
    import aiss_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_second,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_scan_start,
    input wire logic i_scan_step,
    output logic [15:0] o_rdata,
    output aiss_sel_s o_sel,
    output logic o_sel_a_low_ref,
    output logic o_sel_b_low_ref,
    output logic [4:0] o_scan_input,
    output logic o_scan_low_ref,
    output logic o_scan_valid,
    output logic o_scan_last,
    output logic o_scan_busy
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    aiss_bus_s bus;
    logic [15:0] ch0_sel, scan_hi;
    logic [5:0] present;
    logic [4:0] sc_input;
    logic sc_valid, sc_last, sc_busy;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    aiss_regs u_regs (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_second(i_second),
        .i_bus(bus),
        .o_ch0_sel(ch0_sel),
        .o_scan_hi(scan_hi),
        .o_present(present)
    );

    aiss_scan u_scan (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_start(i_scan_start),
        .i_step(i_scan_step),
        .i_mask(scan_hi),
        .o_input(sc_input),
        .o_valid(sc_valid),
        .o_last(sc_last),
        .o_busy(sc_busy)
    );

    // An input number at or above the pin count has no pin on this variant.
    function automatic logic no_pin(input logic [4:0] n, input logic [5:0] cnt);
        no_pin = ({1'b0, n} >= cnt);
    endfunction

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    logic [15:0] rdata_q, rdata_d;
    aiss_sel_s sel_q, sel_d;
    logic a_low_q, a_low_d, b_low_q, b_low_d;
    logic [4:0] sin_q, sin_d;
    logic slow_q, slow_d, sval_q, sval_d, slast_q, slast_d, sbusy_q, sbusy_d;

    always_comb begin
        rdata_d = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                REG_CH0_SEL: rdata_d = ch0_sel;
                REG_SCAN_HI: rdata_d = scan_hi;
                REG_CFG: rdata_d = {10'h000, present};
                REG_STATUS: rdata_d = {10'h000, sc_busy, sc_valid, 4'h0};
                default: rdata_d = 16'h0000;
            endcase
        end
        sel_d.pos_a = ch0_sel[POS_A_LSB +: SEL_W];
        sel_d.pos_b = ch0_sel[POS_B_LSB +: SEL_W];
        sel_d.neg_pin_a = ch0_sel[NEG_A_BIT];
        sel_d.neg_pin_b = ch0_sel[NEG_B_BIT];
        a_low_d = no_pin(sel_d.pos_a, present);
        b_low_d = no_pin(sel_d.pos_b, present);
        sin_d = sc_input;
        slow_d = sc_valid && no_pin(sc_input, present);
        sval_d = sc_valid;
        slast_d = sc_last;
        sbusy_d = sc_busy;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rdata_q <= 16'h0000;
            sel_q <= '0;
            a_low_q <= 1'b0;
            b_low_q <= 1'b0;
            sin_q <= 5'h00;
            slow_q <= 1'b0;
            sval_q <= 1'b0;
            slast_q <= 1'b0;
            sbusy_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            sel_q <= sel_d;
            a_low_q <= a_low_d;
            b_low_q <= b_low_d;
            sin_q <= sin_d;
            slow_q <= slow_d;
            sval_q <= sval_d;
            slast_q <= slast_d;
            sbusy_q <= sbusy_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_sel = sel_q;
    assign o_sel_a_low_ref = a_low_q;
    assign o_sel_b_low_ref = b_low_q;
    assign o_scan_input = sin_q;
    assign o_scan_low_ref = slow_q;
    assign o_scan_valid = sval_q;
    assign o_scan_last = slast_q;
    assign o_scan_busy = sbusy_q;
endmodule

// file: tb/aiss_top_sva.sv
module aiss_top_sva
    import aiss_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_second,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_scan_step,
    input wire logic [15:0] o_rdata,
    input wire aiss_sel_s o_sel,
    input wire logic [4:0] o_scan_input,
    input wire logic o_scan_valid,
    input wire logic o_scan_busy
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    a_reset_clear: assert property ($rose(i_rstn) |-> o_sel == '0 && o_rdata == 16'h0000)
        else $error("outputs not clear after reset");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside the read answer cycle");
    a_ch0_unimpl: assert property ($past(i_rd) && $past(i_addr) == REG_CH0_SEL |-> (o_rdata & ~CH0_SEL_MASK) == 16'h0000)
        else $error("unimplemented select bits read nonzero");
    a_neg_a_sel: assert property (i_wr && i_addr == REG_CH0_SEL |-> ##2 o_sel.neg_pin_a == $past(i_wdata[NEG_A_BIT], 2))
        else $error("negative select A not taken from bit 7");
    a_pos_a_clip: assert property (i_wr && i_addr == REG_CH0_SEL |-> ##2 o_sel.pos_a ==
        (($past(i_second, 2) && $past(i_wdata[4], 2)) ? 5'h0F : $past(i_wdata[4:0], 2)))
        else $error("positive select A wrong or not clipped");
    a_scan_range: assert property (o_scan_valid |-> o_scan_input[4] && o_scan_busy)
        else $error("scan input outside upper range");
    // Valid shows one cycle late, so the cycle just after a step is not a hold cycle.
    a_scan_hold: assert property (o_scan_valid && !i_scan_step && !$past(i_scan_step) |=>
        o_scan_valid && $stable(o_scan_input))
        else $error("scan input dropped before step");
    a_step_advance: assert property (o_scan_valid && i_scan_step |=> ##1 !o_scan_valid)
        else $error("scan input held after step");
endmodule

bind aiss_top aiss_top_sva i_sva (.i_clk_sys, .i_rstn, .i_second, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_scan_step, .o_rdata, .o_sel, .o_scan_input, .o_scan_valid, .o_scan_busy);

// file: tb/tb_top.sv
module tb_top
    import aiss_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 20;
    logic i_clk_sys, i_rstn, i_second, i_wr, i_rd, i_scan_start, i_scan_step;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, d, e;
    aiss_sel_s o_sel;
    logic o_sel_a_low_ref, o_sel_b_low_ref, o_scan_low_ref, o_scan_valid, o_scan_last, o_scan_busy;
    logic [4:0] o_scan_input;
    logic [31:0] seed = 32'h00017432;
    int failures = 0;
    int checks_done = 0;

    aiss_top i_dut (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_second(i_second),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_scan_start(i_scan_start),
        .i_scan_step(i_scan_step),
        .o_rdata(o_rdata),
        .o_sel(o_sel),
        .o_sel_a_low_ref(o_sel_a_low_ref),
        .o_sel_b_low_ref(o_sel_b_low_ref),
        .o_scan_input(o_scan_input),
        .o_scan_low_ref(o_scan_low_ref),
        .o_scan_valid(o_scan_valid),
        .o_scan_last(o_scan_last),
        .o_scan_busy(o_scan_busy)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] ech0(input logic [15:0] v, input logic s);
        ech0 = v & 16'h9F9F;
        if (s && v[4]) ech0[4:0] = 5'h0F;
        if (s && v[12]) ech0[12:8] = 5'h0F;
    endfunction

    task automatic wrap_up();
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] got);
        checks_done++;
        if (got !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] x);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk("rdata", x, o_rdata);
    endtask

    // --------------------------------------------------------------------
    // Scan walk
    // --------------------------------------------------------------------
    // A stuck sequencer must not hang the run, so the wait gives up and counts a mismatch.
    task automatic wt(input logic lvl);
        int n;
        n = 0;
        while (o_scan_valid !== lvl) begin
            @(posedge i_clk_sys);
            #1;
            n++;
            if (n > 64) begin
                chk("scan wait", 16'h0001, 16'h0000);
                wrap_up();
            end
        end
    endtask

    task automatic scan(input logic [15:0] m);
        wr(REG_SCAN_HI, m);
        @(posedge i_clk_sys);
        i_scan_start <= 1'b1;
        @(posedge i_clk_sys);
        i_scan_start <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            if (m[k]) begin
                wt(1'b1);
                chk("scan input", 16'(16 + k), {11'h000, o_scan_input});
                chk("scan low ref", {15'h0000, (16 + k) >= PC}, {15'h0000, o_scan_low_ref});
                chk("scan last", {15'h0000, (m >> (k + 1)) == 16'h0000}, {15'h0000, o_scan_last});
                chk("scan busy", 16'h0001, {15'h0000, o_scan_busy});
                rd(REG_STATUS, 16'h0030);
                @(posedge i_clk_sys);
                i_scan_step <= 1'b1;
                @(posedge i_clk_sys);
                i_scan_step <= 1'b0;
                #1;
                wt(1'b0);
            end
        end
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk("scan idle", 16'h0000, {15'h0000, o_scan_busy});
    endtask

    initial begin
        {i_rstn, i_second, i_wr, i_rd, i_scan_start, i_scan_step} = 6'h00;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        rd(REG_CH0_SEL, CH0_SEL_RESET);
        rd(REG_SCAN_HI, SCAN_HI_RESET);
        wr(REG_CFG, 16'h0014);
        rd(REG_CFG, 16'h0014);
        for (int i = 0; i < 24; i++) begin
            d = 16'(rnd());
            if (i == 0) d = 16'hFFFF;
            if (i == 1) d = 16'h9F9F;
            @(posedge i_clk_sys) i_second <= d[13];
            e = ech0(d, d[13]);
            wr(REG_CH0_SEL, d);
            @(posedge i_clk_sys);
            #1;
            chk("sel", {4'h0, e[15], e[12:8], e[7], e[4:0]}, {4'h0, o_sel});
            chk("low ref a", {15'h0000, e[4:0] >= PC}, {15'h0000, o_sel_a_low_ref});
            chk("low ref b", {15'h0000, e[12:8] >= PC}, {15'h0000, o_sel_b_low_ref});
            rd(REG_CH0_SEL, e);
            d = 16'(rnd());
            wr(REG_SCAN_HI, d);
            rd(REG_SCAN_HI, d);
        end
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        scan(16'h8001);
        repeat (3) scan(16'(rnd()) | 16'h0001);
        wrap_up();
    end
endmodule
